// ---- bench/tb_tcca_arbiter.sv ----
// self-checking bench for the tape channel control arbiter
`timescale 1ns/1ps
module tb_tcca_arbiter import tcca_pkg::*; ;
    logic core_clk = 1'h0;
    logic rst_b = 1'h0;
    logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0;
    logic arvalid = 1'h0, rready = 1'h0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, st;
    logic awready, wready, bvalid, arready, rvalid, rd_busy, wr_busy;
    logic [1:0] bresp, rresp, resp;
    logic rd_own, wr_own, rd_sel, wr_sel, rd_stb, wr_stb, pri_int;
    logic wr_coded, sat_int;
    logic [3:0] wr_unit, u;
    logic [2:0] rd_op, wr_op;
    int miscompares = 0, comparisons = 0;
    // 40 MHz clock
    always #12.5 core_clk = ~core_clk;
    tcca_arbiter dut (.CORE_CLK(core_clk), .RST_B(rst_b),
        .AWVALID(awvalid), .AWREADY(awready), .AWADDR(awaddr),
        .AWPROT(3'h0), .WVALID(wvalid), .WREADY(wready), .WDATA(wdata),
        .WSTRB(4'hF), .BVALID(bvalid), .BREADY(bready), .BRESP(bresp),
        .ARVALID(arvalid), .ARREADY(arready), .ARADDR(araddr),
        .ARPROT(3'h0), .RVALID(rvalid), .RREADY(rready), .RDATA(rdata),
        .RRESP(rresp), .RD_MOTION_BUSY(rd_busy), .WR_MOTION_BUSY(wr_busy),
        .READ_CHANNEL_OWNER(rd_own), .WRITE_CHANNEL_OWNER(wr_own),
        .RD_SEL_VALID(rd_sel), .RD_UNIT(), .RD_CODED(),
        .WR_SEL_VALID(wr_sel), .WR_UNIT(wr_unit), .WR_CODED(wr_coded),
        .RD_OP_STB(rd_stb), .RD_OP(rd_op), .WR_OP_STB(wr_stb),
        .WR_OP(wr_op),
        .DT_SAT_TO_PRI(), .DT_PRI_TO_SAT(), .PRI_INT(pri_int),
        .SAT_INT(sat_int));
    tcca_tape_model tape (.clk(core_clk), .rd_stb(rd_stb),
        .wr_stb(wr_stb), .rd_busy(rd_busy), .wr_busy(wr_busy));
    // compare one value and count it
    task automatic chk(input string n, input logic [31:0] got, exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", n, exp, got);
        end
    endtask
    // one write, address and data offered together
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        awvalid <= 1'h1;
        wvalid <= 1'h1;
        awaddr <= a;
        wdata <= d;
        bready <= 1'h1;
        do begin
            @(posedge core_clk);
            if (awready === 1'h1) awvalid <= 1'h0;
            if (wready === 1'h1) wvalid <= 1'h0;
        end while (bvalid !== 1'h1);
        resp = bresp;
        bready <= 1'h0;
    endtask
    // one read of a register into st
    task automatic rd(input logic [7:0] a);
        @(posedge core_clk);
        arvalid <= 1'h1;
        araddr <= a;
        rready <= 1'h1;
        do begin
            @(posedge core_clk);
            if (arready === 1'h1) arvalid <= 1'h0;
        end while (rvalid !== 1'h1);
        st = rdata;
        rready <= 1'h0;
    endtask
    // command word: opcode and unit
    task automatic cmd(input logic [7:0] a, input logic [4:0] op,
                       input logic [3:0] n = 4'h0);
        wr(a, {20'h0, n, 3'h0, op});
    endtask
    // verdict and end of run
    task automatic finish_test;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // hang guard, well beyond the few hundred cycles needed
    initial begin
        #200000;
        miscompares++;
        finish_test();
    end
    // main sequence
    initial begin
        u = 4'($urandom(73142));
        repeat (5) @(posedge core_clk);
        rst_b <= 1'h1;
        rd(OFF_STATUS);
        chk("status", st, 32'h0);
        cmd(OFF_SAT_CMD, P_WR_GRANT);
        rd(OFF_STATUS);
        chk("handover", st & 32'hF, 32'h0);
        cmd(OFF_PRI_CMD, C_WR_RELEASE);
        chk("no-op release", {31'h0, wr_own}, 32'h0);
        $display("test reset and refusal done");
        cmd(OFF_PRI_CMD, P_SEL_WR_CODED, u);
        chk("wr select", {27'h0, wr_sel, wr_unit}, {27'h0, 1'h1, u});
        chk("wr coded", {31'h0, wr_coded}, 32'h1);
        cmd(OFF_PRI_CMD, P_WR_GRANT);
        rd(OFF_STATUS);
        chk("wr handover", st & 32'h2, 32'h2);
        repeat (4) @(posedge core_clk);
        chk("wr owner", {30'h0, wr_own, wr_sel}, 32'h2);
        cmd(OFF_PRI_CMD, P_SEL_WR_BIN, u);
        chk("wr select refused", {31'h0, wr_sel}, 32'h0);
        cmd(OFF_PRI_CMD, C_WR_RELEASE);
        repeat (4) @(posedge core_clk);
        chk("wr reclaimed", {31'h0, wr_own}, 32'h0);
        cmd(OFF_PRI_CMD, P_SEL_WR_BIN, u);
        chk("wr reselect", {31'h0, wr_sel}, 32'h1);
        cmd(OFF_SAT_CMD, C_WR_BASE + 5'(TOP_CODED));
        chk("wr op refused", {29'h0, wr_op}, {29'h0, TOP_BIN});
        cmd(OFF_PRI_CMD, C_WR_BASE + 5'(TOP_CODED));
        chk("wr op", {29'h0, wr_op}, {29'h0, TOP_CODED});
        $display("test write handover done");
        cmd(OFF_PRI_CMD, P_SEL_RD_BIN, u);
        cmd(OFF_PRI_CMD, C_RD_BASE + 5'(TOP_REWIND));
        repeat (3) @(posedge core_clk);
        chk("rd op", {29'h0, rd_op}, {29'h0, TOP_REWIND});
        cmd(OFF_PRI_CMD, P_RD_GRANT);
        chk("rd owner in motion", {31'h0, rd_own}, 32'h0);
        repeat (12) @(posedge core_clk);
        chk("rd owner", {30'h0, rd_own, rd_sel}, 32'h2);
        cmd(OFF_PRI_CMD, P_IRQ_RD_READY);
        cmd(OFF_SAT_CMD, C_RD_RELEASE);
        repeat (4) @(posedge core_clk);
        chk("rd released", {31'h0, rd_own}, 32'h0);
        $display("test read handover done");
        cmd(OFF_SAT_CMD, S_FLAG1_SET);
        cmd(OFF_SAT_CMD, S_FLAG2_SET);
        cmd(OFF_SAT_CMD, S_IRQ_ACTION_ON);
        cmd(OFF_PRI_CMD, P_DT_PRI_TO_SAT);
        cmd(OFF_PRI_CMD, P_ACTION_SET);
        rd(OFF_STATUS);
        chk("flags set", st & 32'h14000BC0, 32'h140009C0);
        chk("sat int", {31'h0, sat_int}, 32'h1);
        cmd(OFF_PRI_CMD, P_MASTER_CLEAR);
        cmd(OFF_SAT_CMD, S_ACTION_DROP);
        cmd(OFF_SAT_CMD, S_RAISE_INT);
        rd(OFF_STATUS);
        chk("flags cleared", st & 32'h3C0, 32'h200);
        chk("pri int", {31'h0, pri_int}, 32'h1);
        chk("sat int off", {31'h0, sat_int}, 32'h0);
        cmd(OFF_PRI_CMD, P_SAT_INT_CLEAR);
        repeat (2) @(posedge core_clk);
        chk("pri int clear", {31'h0, pri_int}, 32'h0);
        wr(8'h0C, $urandom);
        chk("unmapped", {30'h0, resp}, {30'h0, RESP_SLVERR});
        $display("test flags and bus done");
        finish_test();
    end
endmodule // tb_tcca_arbiter

// ---- bench/tcca_tape_model.sv ----
// tape transport model: motion busy after each op strobe
`timescale 1ns/1ps
module tcca_tape_model #(
    parameter int MOTION = 12
) (
    input wire logic clk,
    input wire logic rd_stb,
    input wire logic wr_stb,
    output logic rd_busy,
    output logic wr_busy
);
    int rd_cnt = 0;
    int wr_cnt = 0;
    // each strobe starts a motion that runs MOTION cycles
    always @(posedge clk) begin
        rd_cnt <= rd_stb ? MOTION : (rd_cnt > 0 ? rd_cnt - 1 : 0);
        wr_cnt <= wr_stb ? MOTION : (wr_cnt > 0 ? wr_cnt - 1 : 0);
    end
    assign rd_busy = (rd_cnt > 0);
    assign wr_busy = (wr_cnt > 0);
endmodule // tcca_tape_model

// ---- core/tcca_arbiter.sv ----
// tape channel control arbiter for a primary and a satellite host
//
// Overview of operation
// - only primary grants channels to satellite
// - grant sets handover, release clears it
// - handover latches readable by both hosts
// - owner follows handover after motion finishes
// - owner change clears that channel's select
// - no simultaneous releases from both hosts
// - interrupt choice allowed regardless of ownership
// - unit select accepted from primary only
// - primary select needs primary channel ownership
// - primary reclaims anytime, motion completes first
// - primary command set implemented
// - common tape commands for both hosts
// - satellite raises interrupt, drops action request
// - communication flags, master clear clears both
//
// Chosen here: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
module tcca_arbiter
    import tcca_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic RST_B,
    input wire logic AWVALID,
    output logic AWREADY,
    input wire logic [ADDR_W-1:0] AWADDR,
    input wire logic [2:0] AWPROT,
    input wire logic WVALID,
    output logic WREADY,
    input wire logic [DATA_W-1:0] WDATA,
    input wire logic [3:0] WSTRB,
    output logic BVALID,
    input wire logic BREADY,
    output logic [1:0] BRESP,
    input wire logic ARVALID,
    output logic ARREADY,
    input wire logic [ADDR_W-1:0] ARADDR,
    input wire logic [2:0] ARPROT,
    output logic RVALID,
    input wire logic RREADY,
    output logic [DATA_W-1:0] RDATA,
    output logic [1:0] RRESP,
    input wire logic RD_MOTION_BUSY,
    input wire logic WR_MOTION_BUSY,
    output logic READ_CHANNEL_OWNER,
    output logic WRITE_CHANNEL_OWNER,
    output logic RD_SEL_VALID,
    output logic [UNIT_W-1:0] RD_UNIT,
    output logic RD_CODED,
    output logic WR_SEL_VALID,
    output logic [UNIT_W-1:0] WR_UNIT,
    output logic WR_CODED,
    output logic RD_OP_STB,
    output logic [2:0] RD_OP,
    output logic WR_OP_STB,
    output logic [2:0] WR_OP,
    output logic DT_SAT_TO_PRI,
    output logic DT_PRI_TO_SAT,
    output logic PRI_INT,
    output logic SAT_INT
);
    // decode a common tape command: {valid, op}
    function automatic logic [3:0] com_dec(input logic [4:0] op,
                                           input logic [4:0] base);
        logic [4:0] diff;
        diff = op - base;
        com_dec = {(op >= base) && (op <= base + 5'h04), diff[2:0]};
    endfunction

    logic aw_full_reg, w_full_reg, awready_reg, wready_reg;
    logic bvalid_reg, arready_reg, rvalid_reg;
    logic [1:0] bresp_reg, rresp_reg;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic [DATA_W-1:0] wdata_reg, rdata_reg;
    logic [3:0] wstrb_reg;
    logic [1:0] hand_reg, owner_reg, sel_reg, coded_reg, stb_reg;
    logic [UNIT_W-1:0] unit_reg [2];
    logic [2:0] op_reg [2];
    logic flag1_reg, flag2_reg, action_reg, sat_int_reg;
    logic dt_s2p_reg, dt_p2s_reg;
    logic irq_rd_reg, irq_wr_reg, irq_act_reg, pri_int_reg, sat_irq_reg;
    logic [1:0] busy_s;
    logic wr_go, cmd_ok, pri_cmd, sat_cmd;
    logic [4:0] op;
    logic [1:0] grant, release_c, sel_cmd, follow, com_ok;
    logic [3:0] com [2];
    logic [DATA_W-1:0] status;

    // motion busy pins cross into the core clock
    tcca_sync #(.W(2)) u_sync (
        .clk(CORE_CLK),
        .rst_b(RST_B),
        .d({WR_MOTION_BUSY, RD_MOTION_BUSY}),
        .q(busy_s)
    );

    // command decode from a completed bus write
    always_comb begin
        wr_go = aw_full_reg && w_full_reg && !bvalid_reg;
        cmd_ok = wr_go && (wstrb_reg[1:0] == 2'h3);
        pri_cmd = cmd_ok && (aw_addr_reg == OFF_PRI_CMD);
        sat_cmd = cmd_ok && (aw_addr_reg == OFF_SAT_CMD);
        op = wdata_reg[OP_LSB +: OP_W];
        grant[CH_RD] = pri_cmd && (op == P_RD_GRANT);
        grant[CH_WR] = pri_cmd && (op == P_WR_GRANT);
        // bus serialises writes, so two releases never coincide
        release_c[CH_RD] = (pri_cmd || sat_cmd) && (op == C_RD_RELEASE);
        release_c[CH_WR] = (pri_cmd || sat_cmd) && (op == C_WR_RELEASE);
        sel_cmd[CH_RD] = pri_cmd && (op == P_SEL_RD_BIN
                                     || op == P_SEL_RD_CODED);
        sel_cmd[CH_WR] = pri_cmd && (op == P_SEL_WR_BIN
                                     || op == P_SEL_WR_CODED);
        com[CH_RD] = com_dec(op, C_RD_BASE);
        com[CH_WR] = com_dec(op, C_WR_BASE);
        for (int c = 0; c < 2; c++) begin
            follow[c] = (owner_reg[c] != hand_reg[c]) && !busy_s[c];
            com_ok[c] = (pri_cmd || sat_cmd) && com[c][3]
                        && (owner_reg[c] == sat_cmd) && sel_reg[c]
                        && !follow[c];
        end
    end

    // status word seen by either host
    always_comb begin
        status = '0;
        status[ST_RD_HAND] = hand_reg[CH_RD];
        status[ST_WR_HAND] = hand_reg[CH_WR];
        status[ST_RD_OWN] = owner_reg[CH_RD];
        status[ST_WR_OWN] = owner_reg[CH_WR];
        status[ST_RD_SEL] = sel_reg[CH_RD];
        status[ST_WR_SEL] = sel_reg[CH_WR];
        status[ST_FLAG1] = flag1_reg;
        status[ST_FLAG2] = flag2_reg;
        status[ST_ACTION] = action_reg;
        status[ST_SAT_INT] = sat_int_reg;
        status[ST_DT_S2P] = dt_s2p_reg;
        status[ST_DT_P2S] = dt_p2s_reg;
        status[ST_RD_BUSY] = busy_s[CH_RD];
        status[ST_WR_BUSY] = busy_s[CH_WR];
        status[ST_RD_UNIT +: UNIT_W] = unit_reg[CH_RD];
        status[ST_WR_UNIT +: UNIT_W] = unit_reg[CH_WR];
        status[ST_RD_CODED] = coded_reg[CH_RD];
        status[ST_WR_CODED] = coded_reg[CH_WR];
        status[ST_IRQ_RD] = irq_rd_reg;
        status[ST_IRQ_WR] = irq_wr_reg;
        status[ST_IRQ_ACT] = irq_act_reg;
    end

    // write address, write data and response channels
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            aw_full_reg <= 1'b0;
            w_full_reg <= 1'b0;
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
            aw_addr_reg <= '0;
            wdata_reg <= '0;
            wstrb_reg <= '0;
        end else begin
            if (AWVALID && awready_reg) begin
                aw_full_reg <= 1'b1;
                awready_reg <= 1'b0;
                aw_addr_reg <= AWADDR;
            end
            if (WVALID && wready_reg) begin
                w_full_reg <= 1'b1;
                wready_reg <= 1'b0;
                wdata_reg <= WDATA;
                wstrb_reg <= WSTRB;
            end
            if (wr_go) begin
                aw_full_reg <= 1'b0;
                w_full_reg <= 1'b0;
                bvalid_reg <= 1'b1;
                bresp_reg <= (pri_cmd || sat_cmd) ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid_reg && BREADY) begin
                bvalid_reg <= 1'b0;
                awready_reg <= 1'b1;
                wready_reg <= 1'b1;
            end
        end
    end

    // read address and read data channels
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg <= '0;
            rresp_reg <= RESP_OKAY;
        end else if (ARVALID && arready_reg) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rdata_reg <= (ARADDR == OFF_STATUS) ? status : '0;
            rresp_reg <= (ARADDR == OFF_STATUS || ARADDR == OFF_PRI_CMD
                          || ARADDR == OFF_SAT_CMD) ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_reg && RREADY) begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
        end
    end

    // handover latches: primary grant sets, any release clears
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            hand_reg <= RST_HAND;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (grant[c]) begin
                    hand_reg[c] <= 1'b1;
                end else if (release_c[c]) begin
                    hand_reg[c] <= 1'b0;
                end
            end
        end
    end

    // owner latches and unit selects per channel
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            owner_reg <= RST_OWNER;
            sel_reg <= 2'h0;
            coded_reg <= 2'h0;
            unit_reg[CH_RD] <= '0;
            unit_reg[CH_WR] <= '0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                if (follow[c]) begin
                    owner_reg[c] <= hand_reg[c];
                    sel_reg[c] <= 1'b0;
                end else if (sel_cmd[c] && !owner_reg[c]) begin
                    sel_reg[c] <= 1'b1;
                    unit_reg[c] <= wdata_reg[UNIT_LSB +: UNIT_W];
                    coded_reg[c] <= (op == P_SEL_RD_CODED)
                                    || (op == P_SEL_WR_CODED);
                end
            end
        end
    end

    // tape operation strobes from the owning host
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            stb_reg <= 2'h0;
            op_reg[CH_RD] <= TOP_BIN;
            op_reg[CH_WR] <= TOP_BIN;
        end else begin
            for (int c = 0; c < 2; c++) begin
                stb_reg[c] <= com_ok[c];
                if (com_ok[c]) begin
                    op_reg[c] <= com[c][2:0];
                end
            end
        end
    end

    // host-to-host signalling: flags, action request, interrupt, transfer
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            flag1_reg <= 1'b0;
            flag2_reg <= 1'b0;
            action_reg <= 1'b0;
            sat_int_reg <= 1'b0;
            dt_s2p_reg <= 1'b0;
            dt_p2s_reg <= 1'b0;
        end else begin
            if ((pri_cmd && op == P_FLAG1_SET)
                || (sat_cmd && op == S_FLAG1_SET))
                flag1_reg <= 1'b1;
            else if ((pri_cmd && (op == P_FLAG1_CLR || op == P_MASTER_CLEAR))
                     || (sat_cmd && op == S_FLAG1_CLR))
                flag1_reg <= 1'b0;
            if (sat_cmd && op == S_FLAG2_SET)
                flag2_reg <= 1'b1;
            else if ((pri_cmd && (op == P_FLAG2_CLR || op == P_MASTER_CLEAR))
                     || (sat_cmd && op == S_FLAG2_CLR))
                flag2_reg <= 1'b0;
            if (pri_cmd && op == P_ACTION_SET)
                action_reg <= 1'b1;
            else if (sat_cmd && op == S_ACTION_DROP)
                action_reg <= 1'b0;
            if (sat_cmd && op == S_RAISE_INT)
                sat_int_reg <= 1'b1;
            else if (pri_cmd && op == P_SAT_INT_CLEAR)
                sat_int_reg <= 1'b0;
            if (pri_cmd && op == P_DT_SAT_TO_PRI) begin
                dt_s2p_reg <= 1'b1;
                dt_p2s_reg <= 1'b0;
            end else if (pri_cmd && op == P_DT_PRI_TO_SAT) begin
                dt_s2p_reg <= 1'b0;
                dt_p2s_reg <= 1'b1;
            end else if (pri_cmd && op == P_DT_CLEAR) begin
                dt_s2p_reg <= 1'b0;
                dt_p2s_reg <= 1'b0;
            end
        end
    end

    // interrupt choices, taken whoever owns the channels
    always_ff @(posedge CORE_CLK or negedge RST_B) begin
        if (!RST_B) begin
            irq_rd_reg <= 1'b0;
            irq_wr_reg <= 1'b0;
            irq_act_reg <= 1'b0;
            pri_int_reg <= 1'b0;
            sat_irq_reg <= 1'b0;
        end else begin
            if (pri_cmd && op == P_IRQ_RD_READY)
                irq_rd_reg <= 1'b1;
            if (pri_cmd && op == P_IRQ_WR_READY)
                irq_wr_reg <= 1'b1;
            if (pri_cmd && op == P_IRQ_CLEAR) begin
                irq_rd_reg <= 1'b0;
                irq_wr_reg <= 1'b0;
            end
            if (sat_cmd && op == S_IRQ_ACTION_ON)
                irq_act_reg <= 1'b1;
            else if (sat_cmd && op == S_IRQ_ACTION_OFF)
                irq_act_reg <= 1'b0;
            pri_int_reg <= sat_int_reg
                || (irq_rd_reg && sel_reg[CH_RD] && !busy_s[CH_RD])
                || (irq_wr_reg && sel_reg[CH_WR] && !busy_s[CH_WR]);
            sat_irq_reg <= irq_act_reg && action_reg;
        end
    end

    // outputs straight from flip-flops
    assign AWREADY = awready_reg;
    assign WREADY = wready_reg;
    assign BVALID = bvalid_reg;
    assign BRESP = bresp_reg;
    assign ARREADY = arready_reg;
    assign RVALID = rvalid_reg;
    assign RDATA = rdata_reg;
    assign RRESP = rresp_reg;
    assign READ_CHANNEL_OWNER = owner_reg[CH_RD];
    assign WRITE_CHANNEL_OWNER = owner_reg[CH_WR];
    assign RD_SEL_VALID = sel_reg[CH_RD];
    assign WR_SEL_VALID = sel_reg[CH_WR];
    assign RD_UNIT = unit_reg[CH_RD];
    assign WR_UNIT = unit_reg[CH_WR];
    assign RD_CODED = coded_reg[CH_RD];
    assign WR_CODED = coded_reg[CH_WR];
    assign RD_OP_STB = stb_reg[CH_RD];
    assign WR_OP_STB = stb_reg[CH_WR];
    assign RD_OP = op_reg[CH_RD];
    assign WR_OP = op_reg[CH_WR];
    assign DT_SAT_TO_PRI = dt_s2p_reg;
    assign DT_PRI_TO_SAT = dt_p2s_reg;
    assign PRI_INT = pri_int_reg;
    assign SAT_INT = sat_irq_reg;

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RST_B);

    // checks on arbitration and signalling
    sequence s_stat_req;
        ARVALID && arready_reg && (ARADDR == OFF_STATUS);
    endsequence
    sequence s_sat_raise;
        sat_cmd && (op == S_RAISE_INT);
    endsequence
    property p_hand_rise_by_primary;
        $rose(hand_reg[CH_WR]) |-> $past(grant[CH_WR]);
    endproperty
    a_hand_rise_by_primary: assert property (p_hand_rise_by_primary)
        else $error("write handover set without primary grant");
    property p_release_clears;
        release_c[CH_RD] && !grant[CH_RD] |=> !hand_reg[CH_RD];
    endproperty
    a_release_clears: assert property (p_release_clears)
        else $error("read release did not clear handover");
    property p_status_read;
        s_stat_req |=> rvalid_reg && (rdata_reg[1:0] == $past(hand_reg));
    endproperty
    a_status_read: assert property (p_status_read)
        else $error("status read lost handover bits");
    property p_owner_waits;
        $changed(owner_reg[CH_RD]) |-> $past(!busy_s[CH_RD]);
    endproperty
    a_owner_waits: assert property (p_owner_waits)
        else $error("read owner changed during motion");
    property p_owner_follows;
        (owner_reg[CH_WR] != hand_reg[CH_WR]) && !busy_s[CH_WR]
            |=> owner_reg[CH_WR] == $past(hand_reg[CH_WR]);
    endproperty
    a_owner_follows: assert property (p_owner_follows)
        else $error("write owner failed to follow handover");
    property p_change_clears_sel;
        $changed(owner_reg) |-> (sel_reg & (owner_reg ^ $past(owner_reg)))
                                == 2'h0;
    endproperty
    a_change_clears_sel: assert property (p_change_clears_sel)
        else $error("select survived ownership change");
    property p_sel_primary_owner;
        $rose(sel_reg[CH_RD]) |-> $past(sel_cmd[CH_RD] && !owner_reg[CH_RD]);
    endproperty
    a_sel_primary_owner: assert property (p_sel_primary_owner)
        else $error("read select without primary ownership");
    property p_irq_anytime;
        pri_cmd && (op == P_IRQ_RD_READY) |=> irq_rd_reg;
    endproperty
    a_irq_anytime: assert property (p_irq_anytime)
        else $error("interrupt choice refused");
    property p_sat_int_path;
        s_sat_raise |=> sat_int_reg ##1 pri_int_reg;
    endproperty
    a_sat_int_path: assert property (p_sat_int_path)
        else $error("satellite interrupt did not reach primary");
    property p_master_clear;
        pri_cmd && (op == P_MASTER_CLEAR) |=> !flag1_reg && !flag2_reg;
    endproperty
    a_master_clear: assert property (p_master_clear)
        else $error("master clear left a flag set");
    property p_common_owner_only;
        sat_cmd && com[CH_WR][3] && !owner_reg[CH_WR] |=> !stb_reg[CH_WR];
    endproperty
    a_common_owner_only: assert property (p_common_owner_only)
        else $error("tape op from non-owner host");
endmodule // tcca_arbiter

// ---- core/tcca_pkg.sv ----
// constants for the tape channel control arbiter
package tcca_pkg;
    // register bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [ADDR_W-1:0] OFF_PRI_CMD = 8'h00;
    localparam logic [ADDR_W-1:0] OFF_SAT_CMD = 8'h04;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h08;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // command word fields
    localparam int OP_LSB = 0;
    localparam int OP_W = 5;
    localparam int UNIT_LSB = 8;
    localparam int UNIT_W = 4;
    // channel indices
    localparam int CH_RD = 0;
    localparam int CH_WR = 1;
    // primary host opcodes
    localparam logic [4:0] P_IRQ_RD_READY = 5'h01;
    localparam logic [4:0] P_IRQ_WR_READY = 5'h02;
    localparam logic [4:0] P_IRQ_CLEAR = 5'h03;
    localparam logic [4:0] P_DT_SAT_TO_PRI = 5'h04;
    localparam logic [4:0] P_DT_PRI_TO_SAT = 5'h05;
    localparam logic [4:0] P_DT_CLEAR = 5'h06;
    localparam logic [4:0] P_ACTION_SET = 5'h07;
    localparam logic [4:0] P_SAT_INT_CLEAR = 5'h08;
    localparam logic [4:0] P_SEL_RD_BIN = 5'h09;
    localparam logic [4:0] P_SEL_RD_CODED = 5'h0A;
    localparam logic [4:0] P_SEL_WR_BIN = 5'h0B;
    localparam logic [4:0] P_SEL_WR_CODED = 5'h0C;
    localparam logic [4:0] P_RD_GRANT = 5'h0D;
    localparam logic [4:0] P_WR_GRANT = 5'h0E;
    localparam logic [4:0] P_FLAG1_SET = 5'h0F;
    localparam logic [4:0] P_FLAG1_CLR = 5'h10;
    localparam logic [4:0] P_FLAG2_CLR = 5'h11;
    localparam logic [4:0] P_MASTER_CLEAR = 5'h12;
    // common opcodes, both hosts: base + tape op, then release
    localparam logic [4:0] C_RD_BASE = 5'h14;
    localparam logic [4:0] C_RD_RELEASE = 5'h19;
    localparam logic [4:0] C_WR_BASE = 5'h1A;
    localparam logic [4:0] C_WR_RELEASE = 5'h1F;
    // satellite host opcodes
    localparam logic [4:0] S_RAISE_INT = 5'h01;
    localparam logic [4:0] S_ACTION_DROP = 5'h02;
    localparam logic [4:0] S_FLAG1_SET = 5'h03;
    localparam logic [4:0] S_FLAG1_CLR = 5'h04;
    localparam logic [4:0] S_FLAG2_SET = 5'h05;
    localparam logic [4:0] S_FLAG2_CLR = 5'h06;
    localparam logic [4:0] S_IRQ_ACTION_ON = 5'h07;
    localparam logic [4:0] S_IRQ_ACTION_OFF = 5'h08;
    // tape operation codes
    localparam logic [2:0] TOP_BIN = 3'h0;
    localparam logic [2:0] TOP_CODED = 3'h1;
    localparam logic [2:0] TOP_BACKSPACE = 3'h2;
    localparam logic [2:0] TOP_REWIND = 3'h3;
    localparam logic [2:0] TOP_REWIND_LOCK = 3'h4;
    // status word bit positions
    localparam int ST_RD_HAND = 0;
    localparam int ST_WR_HAND = 1;
    localparam int ST_RD_OWN = 2;
    localparam int ST_WR_OWN = 3;
    localparam int ST_RD_SEL = 4;
    localparam int ST_WR_SEL = 5;
    localparam int ST_FLAG1 = 6;
    localparam int ST_FLAG2 = 7;
    localparam int ST_ACTION = 8;
    localparam int ST_SAT_INT = 9;
    localparam int ST_DT_S2P = 10;
    localparam int ST_DT_P2S = 11;
    localparam int ST_RD_BUSY = 12;
    localparam int ST_WR_BUSY = 13;
    localparam int ST_RD_UNIT = 16;
    localparam int ST_WR_UNIT = 20;
    localparam int ST_RD_CODED = 24;
    localparam int ST_WR_CODED = 25;
    localparam int ST_IRQ_RD = 26;
    localparam int ST_IRQ_WR = 27;
    localparam int ST_IRQ_ACT = 28;
    // reset values: primary owns everything
    localparam logic [1:0] RST_HAND = 2'h0;
    localparam logic [1:0] RST_OWNER = 2'h0;
    localparam int SYNC_STAGES = 2;
endpackage

// ---- core/tcca_sync.sv ----
// two-flop level synchroniser for pin inputs
`timescale 1ns/1ps
module tcca_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_reg;
    logic [W-1:0] q_reg;

    // first stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            meta_reg <= '0;
            q_reg <= '0;
        end else begin
            meta_reg <= d;
            q_reg <= meta_reg;
        end
    end

    assign q = q_reg;
endmodule // tcca_sync
